// [design/iefl_irq_flags.sv]
// Interrupt enable and flag registers with APB access and request output.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps

module iefl_irq_flags
  import iefl_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [IEFL_ADDR_W-1:0] paddr,
  input  wire logic [IEFL_DATA_W-1:0] pwdata,
  output logic      [IEFL_DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   timer_zero_ovf,
  input  wire logic                   external_edge_pin,
  input  wire logic [IEFL_NIB_W-1:0]  port_b_pins,
  input  wire logic                   port_b_read,
  input  wire logic                   parallel_port_access,
  input  wire logic                   converter_done,
  input  wire logic                   serial_rx_full,
  input  wire logic                   serial_tx_empty,
  input  wire logic                   sync_serial_event,
  input  wire logic                   capcmp_one_event,
  input  wire logic                   timer_two_match,
  input  wire logic                   timer_one_ovf,
  input  wire logic                   mem_write_done,
  input  wire logic                   bus_collision,
  input  wire logic                   capcmp_two_event,
  output logic                        irq_request
);

  logic [IEFL_REG_W-1:0] core_irq_control;
  logic [IEFL_REG_W-1:0] periph_irq_flags_a;
  logic [IEFL_REG_W-1:0] periph_irq_flags_b;
  logic [IEFL_REG_W-1:0] periph_irq_enables_a;
  logic [IEFL_REG_W-1:0] periph_irq_enables_b;
  logic [IEFL_REG_W-1:0] option_bits;

  logic [IEFL_IDX_W-1:0] idx;
  logic                  addr_core;
  logic                  addr_flags_a;
  logic                  addr_flags_b;
  logic                  addr_enables_a;
  logic                  addr_enables_b;
  logic                  addr_option;
  logic                  addr_hit;
  logic                  wr_access;
  logic [IEFL_REG_W-1:0] wbyte;
  logic [IEFL_REG_W-1:0] read_byte;
  logic [IEFL_REG_W-1:0] flags_a_view;

  logic                  ext_edge;
  logic                  port_mismatch;
  logic [IEFL_REG_W-1:0] core_set;
  logic [IEFL_REG_W-1:0] flags_a_set;
  logic [IEFL_REG_W-1:0] flags_b_set;
  logic                  core_pending;
  logic                  periph_pending;
  logic                  next_irq_request;

  // ----------------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------------
  iefl_pin_watch u_pin_watch (
    .pclk              (pclk),
    .presetn           (presetn),
    .external_edge_pin (external_edge_pin),
    .port_b_pins       (port_b_pins),
    .edge_select       (option_bits[IEFL_EDGE_SELECT]),
    .port_read         (port_b_read),
    .ext_edge          (ext_edge),
    .port_mismatch     (port_mismatch)
  );

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  assign idx = paddr[IEFL_ADDR_W-1:IEFL_IDX_LSB];

  assign addr_core = (idx == IEFL_IDX_CORE_BANK0)
                   | (idx == IEFL_IDX_CORE_BANK1)
                   | (idx == IEFL_IDX_CORE_BANK2)
                   | (idx == IEFL_IDX_CORE_BANK3);
  assign addr_flags_a   = (idx == IEFL_IDX_FLAGS_A);
  assign addr_flags_b   = (idx == IEFL_IDX_FLAGS_B);
  assign addr_enables_a = (idx == IEFL_IDX_ENABLES_A);
  assign addr_enables_b = (idx == IEFL_IDX_ENABLES_B);
  assign addr_option    = (idx == IEFL_IDX_OPTION);
  assign addr_hit = addr_core | addr_flags_a | addr_flags_b
                  | addr_enables_a | addr_enables_b | addr_option;

  // The slave never inserts wait states; unmapped words answer with an
  // error and no register changes.
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_hit;
  assign wr_access = psel & penable & pwrite & addr_hit;
  assign wbyte     = pwdata[IEFL_REG_W-1:0];

  // ----------------------------------------------------------------------
  // Hardware set terms
  // ----------------------------------------------------------------------
  always_comb begin
    core_set = '0;
    core_set[IEFL_TIMER_ZERO_FLAG]  = timer_zero_ovf;
    core_set[IEFL_EXT_PIN_FLAG]     = ext_edge;
    core_set[IEFL_PORT_CHANGE_FLAG] = port_mismatch;
  end

  always_comb begin
    flags_a_set = '0;
    flags_a_set[IEFL_PARALLEL_PORT]   = parallel_port_access;
    flags_a_set[IEFL_CONVERTER_DONE]  = converter_done;
    flags_a_set[IEFL_SYNC_SERIAL]     = sync_serial_event;
    flags_a_set[IEFL_CAPCMP_ONE]      = capcmp_one_event;
    flags_a_set[IEFL_TIMER_TWO_MATCH] = timer_two_match;
    flags_a_set[IEFL_TIMER_ONE_OVF]   = timer_one_ovf;
  end

  always_comb begin
    flags_b_set = '0;
    flags_b_set[IEFL_MEM_WRITE_DONE] = mem_write_done;
    flags_b_set[IEFL_BUS_COLLISION]  = bus_collision;
    flags_b_set[IEFL_CAPCMP_TWO]     = capcmp_two_event;
  end

  // ----------------------------------------------------------------------
  // Core control register
  // ----------------------------------------------------------------------
  // A hardware event in the cycle of a software write wins, so an event is
  // never lost to a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_control <= IEFL_RESET_BYTE;
    end else if (wr_access && addr_core) begin
      core_irq_control <= wbyte | core_set;
    end else begin
      core_irq_control <= core_irq_control | core_set;
    end
  end

  // ----------------------------------------------------------------------
  // First peripheral flags
  // ----------------------------------------------------------------------
  // Receive and transmit positions are never stored; they mirror the
  // buffer levels, so writes to them are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_flags_a <= IEFL_RESET_BYTE;
    end else if (wr_access && addr_flags_a) begin
      periph_irq_flags_a <= (wbyte & IEFL_FLAGS_A_WR_MASK)
                          | flags_a_set;
    end else begin
      periph_irq_flags_a <= periph_irq_flags_a | flags_a_set;
    end
  end

  always_comb begin
    flags_a_view = periph_irq_flags_a & IEFL_FLAGS_A_WR_MASK;
    flags_a_view[IEFL_SERIAL_RX] = serial_rx_full;
    flags_a_view[IEFL_SERIAL_TX] = serial_tx_empty;
  end

  // ----------------------------------------------------------------------
  // Second peripheral flags
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_flags_b <= IEFL_RESET_BYTE;
    end else if (wr_access && addr_flags_b) begin
      periph_irq_flags_b <= (wbyte & IEFL_B_IMPL_MASK) | flags_b_set;
    end else begin
      periph_irq_flags_b <= periph_irq_flags_b | flags_b_set;
    end
  end

  // ----------------------------------------------------------------------
  // Enable registers and edge option
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_enables_a <= IEFL_RESET_BYTE;
    end else if (wr_access && addr_enables_a) begin
      periph_irq_enables_a <= wbyte;
    end
  end

  // The reserved position is kept as storage so that software reads back
  // what it wrote, but it never feeds the request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_enables_b <= IEFL_RESET_BYTE;
    end else if (wr_access && addr_enables_b) begin
      periph_irq_enables_b <= wbyte & IEFL_B_IMPL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_bits <= IEFL_RESET_BYTE;
    end else if (wr_access && addr_option) begin
      option_bits <= wbyte & IEFL_OPTION_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Read data is captured in the setup phase so that it comes from a flop
  // yet still fits a zero-wait access phase.
  always_comb begin
    read_byte = IEFL_RESET_BYTE;
    if (addr_core) begin
      read_byte = core_irq_control;
    end else if (addr_flags_a) begin
      read_byte = flags_a_view;
    end else if (addr_flags_b) begin
      read_byte = periph_irq_flags_b;
    end else if (addr_enables_a) begin
      read_byte = periph_irq_enables_a;
    end else if (addr_enables_b) begin
      read_byte = periph_irq_enables_b;
    end else if (addr_option) begin
      read_byte = option_bits;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {{(IEFL_DATA_W-IEFL_REG_W){1'b0}}, read_byte};
    end
  end

  // ----------------------------------------------------------------------
  // Request to the core
  // ----------------------------------------------------------------------
  assign core_pending =
      (core_irq_control[IEFL_TIMER_ZERO_ENABLE]
       & core_irq_control[IEFL_TIMER_ZERO_FLAG])
    | (core_irq_control[IEFL_EXT_PIN_ENABLE]
       & core_irq_control[IEFL_EXT_PIN_FLAG])
    | (core_irq_control[IEFL_PORT_CHANGE_ENABLE]
       & core_irq_control[IEFL_PORT_CHANGE_FLAG]);

  assign periph_pending =
      core_irq_control[IEFL_PERIPH_GROUP_ENABLE]
    & ((|(flags_a_view & periph_irq_enables_a))
     | (|(periph_irq_flags_b & periph_irq_enables_b & IEFL_B_IRQ_MASK)));

  assign next_irq_request = core_irq_control[IEFL_GLOBAL_IRQ_ENABLE]
                          & (core_pending | periph_pending);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= next_irq_request;
    end
  end

endmodule

// [design/iefl_pkg.sv]
// Register map, field positions and reset values of the interrupt flag block.
package iefl_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int IEFL_ADDR_W = 12;
  localparam int IEFL_DATA_W = 32;
  localparam int IEFL_REG_W  = 8;
  localparam int IEFL_IDX_W  = 10;
  localparam int IEFL_IDX_LSB = 2;
  localparam int IEFL_NIB_W  = 4;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_CORE_BANK0 = 10'h00B;
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_CORE_BANK1 = 10'h08B;
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_CORE_BANK2 = 10'h10B;
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_CORE_BANK3 = 10'h18B;
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_FLAGS_A    = 10'h00C;
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_FLAGS_B    = 10'h00D;
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_ENABLES_A  = 10'h08C;
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_ENABLES_B  = 10'h08D;
  localparam logic [IEFL_IDX_W-1:0] IEFL_IDX_OPTION     = 10'h081;

  // ----------------------------------------------------------------------
  // Core control fields
  // ----------------------------------------------------------------------
  localparam int IEFL_GLOBAL_IRQ_ENABLE   = 7;
  localparam int IEFL_PERIPH_GROUP_ENABLE = 6;
  localparam int IEFL_TIMER_ZERO_ENABLE   = 5;
  localparam int IEFL_EXT_PIN_ENABLE      = 4;
  localparam int IEFL_PORT_CHANGE_ENABLE  = 3;
  localparam int IEFL_TIMER_ZERO_FLAG     = 2;
  localparam int IEFL_EXT_PIN_FLAG        = 1;
  localparam int IEFL_PORT_CHANGE_FLAG    = 0;

  // ----------------------------------------------------------------------
  // First peripheral flag and enable fields
  // ----------------------------------------------------------------------
  localparam int IEFL_PARALLEL_PORT   = 7;
  localparam int IEFL_CONVERTER_DONE  = 6;
  localparam int IEFL_SERIAL_RX       = 5;
  localparam int IEFL_SERIAL_TX       = 4;
  localparam int IEFL_SYNC_SERIAL     = 3;
  localparam int IEFL_CAPCMP_ONE      = 2;
  localparam int IEFL_TIMER_TWO_MATCH = 1;
  localparam int IEFL_TIMER_ONE_OVF   = 0;

  // ----------------------------------------------------------------------
  // Second peripheral flag and enable fields
  // ----------------------------------------------------------------------
  localparam int IEFL_RESERVED_B      = 6;
  localparam int IEFL_MEM_WRITE_DONE  = 4;
  localparam int IEFL_BUS_COLLISION   = 3;
  localparam int IEFL_CAPCMP_TWO      = 0;

  localparam int IEFL_EDGE_SELECT     = 6;

  // ----------------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [IEFL_REG_W-1:0] IEFL_FLAGS_A_WR_MASK = 8'hCF;
  localparam logic [IEFL_REG_W-1:0] IEFL_B_IMPL_MASK     = 8'h59;
  localparam logic [IEFL_REG_W-1:0] IEFL_B_IRQ_MASK      = 8'h19;
  localparam logic [IEFL_REG_W-1:0] IEFL_OPTION_MASK     = 8'h40;
  localparam logic [IEFL_REG_W-1:0] IEFL_RESET_BYTE      = 8'h00;
  localparam logic [IEFL_NIB_W-1:0] IEFL_RESET_NIB       = 4'h0;

endpackage

// [design/iefl_pin_watch.sv]
// Pin synchronisers, edge detection and port-change mismatch detection.
`timescale 1ns/1ps
module iefl_pin_watch
  import iefl_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  external_edge_pin,
  input  wire logic [IEFL_NIB_W-1:0] port_b_pins,
  input  wire logic                  edge_select,
  input  wire logic                  port_read,
  output logic                       ext_edge,
  output logic                       port_mismatch
);

  logic [IEFL_NIB_W:0]   sync_first;
  logic [IEFL_NIB_W:0]   sync_second;
  logic                  ext_prev;
  logic [2:0]            primed;
  logic [IEFL_NIB_W-1:0] port_latch;

  // ----------------------------------------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_first  <= '0;
      sync_second <= '0;
    end else begin
      sync_first  <= {external_edge_pin, port_b_pins};
      sync_second <= sync_first;
    end
  end

  // ----------------------------------------------------------------------
  // Edge detector
  // ----------------------------------------------------------------------
  // Edges are ignored until the previous-sample flop holds a real pin
  // sample, so a pin that is high at reset release never looks like an edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
      primed   <= '0;
    end else begin
      ext_prev <= sync_second[IEFL_NIB_W];
      primed   <= {primed[1:0], 1'b1};
    end
  end

  always_comb begin
    if (!primed[2]) begin
      ext_edge = 1'b0;
    end else if (edge_select) begin
      ext_edge = sync_second[IEFL_NIB_W] & ~ext_prev;
    end else begin
      ext_edge = ~sync_second[IEFL_NIB_W] & ext_prev;
    end
  end

  // ----------------------------------------------------------------------
  // Port-change mismatch
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch <= IEFL_RESET_NIB;
    end else if (port_read) begin
      port_latch <= sync_second[IEFL_NIB_W-1:0];
    end
  end

  assign port_mismatch = (port_latch != sync_second[IEFL_NIB_W-1:0]);

endmodule

// [verif/iefl_irq_flags_assertions.sv]
// Concurrent checks on the ports of the interrupt flag block.
`timescale 1ns/1ps
module iefl_irq_flags_assertions
  import iefl_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [IEFL_ADDR_W-1:0] paddr,
  input wire logic [IEFL_DATA_W-1:0] pwdata,
  input wire logic [IEFL_DATA_W-1:0] prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   timer_zero_ovf,
  input wire logic                   timer_one_ovf,
  input wire logic                   serial_rx_full,
  input wire logic                   irq_request
);
  logic [IEFL_IDX_W-1:0] idx;
  logic                  wr_acc;
  logic                  core_hit;
  logic                  mapped;
  logic [7:0]            core_sh;
  logic [7:0]            ena_sh;
  logic                  t0_on;
  logic                  t1_on;
  logic                  rx_on;

  // The enables live inside the block, so they are shadowed from the bus
  // writes; hardware never changes enable bits, which keeps this exact.
  assign idx = paddr[IEFL_ADDR_W-1:IEFL_IDX_LSB];
  assign wr_acc = psel && penable && pwrite;
  assign core_hit = idx inside {IEFL_IDX_CORE_BANK0, IEFL_IDX_CORE_BANK1,
                                IEFL_IDX_CORE_BANK2, IEFL_IDX_CORE_BANK3};
  assign mapped = core_hit || idx inside {IEFL_IDX_FLAGS_A, IEFL_IDX_OPTION,
    IEFL_IDX_FLAGS_B, IEFL_IDX_ENABLES_A, IEFL_IDX_ENABLES_B};
  assign t0_on = core_sh[7] && core_sh[5];
  assign t1_on = core_sh[7] && core_sh[6] && ena_sh[0];
  assign rx_on = core_sh[7] && core_sh[6] && ena_sh[5];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_sh <= 8'h00;
    end else if (wr_acc && core_hit) begin
      core_sh <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ena_sh <= 8'h00;
    end else if (wr_acc && idx == IEFL_IDX_ENABLES_A) begin
      ena_sh <= pwdata[7:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_always:
    assert property (pready)
    else $error("pready low");
  a_err_idle:
    assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside an access phase");
  a_err_unmapped:
    assert property (psel && penable && !mapped |-> pslverr)
    else $error("no pslverr on an unmapped access");
  a_rdata_upper:
    assert property (prdata[31:8] == 24'h000000)
    else $error("prdata upper bits not zero");
  a_quiet_reset:
    assert property ($rose(presetn) |-> !irq_request)
    else $error("request right after reset");
  a_global_gate:
    assert property (!core_sh[7] |=> !irq_request)
    else $error("request while global enable clear");
  a_group_gate:
    assert property (core_sh[6:3] == 4'h0 |=> !irq_request)
    else $error("request with group and core enables clear");
  a_timer_zero_irq:
    assert property (timer_zero_ovf && t0_on ##1 t0_on |=> irq_request)
    else $error("timer zero request missing");
  a_timer_one_irq:
    assert property (timer_one_ovf && t1_on ##1 t1_on |=> irq_request)
    else $error("timer one request missing");
  a_rx_irq:
    assert property ((serial_rx_full && rx_on) [*2] |-> irq_request)
    else $error("receive request missing");

  c_unmapped: cover property (psel && penable && !mapped);
  c_irq_rise: cover property ($rose(irq_request));
  c_timer_one_on: cover property (timer_one_ovf && t1_on);
endmodule

bind iefl_irq_flags iefl_irq_flags_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_zero_ovf(timer_zero_ovf),
  .timer_one_ovf(timer_one_ovf), .serial_rx_full(serial_rx_full),
  .irq_request(irq_request)
);

// [verif/iefl_periph_model.sv]
// Peripheral and core model giving one-cycle event pulses.
`timescale 1ns/1ps
module iefl_periph_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic [3:0]  sel,
  output logic      [10:0] pulse
);
  // Events are single cycles, since a held input would set a flag again
  // on every edge and hide a failed software clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse <= 11'h000;
    end else begin
      pulse <= fire ? (11'h001 << sel) : 11'h000;
    end
  end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the interrupt enable and flag block.
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] CORE = 12'h02C;
  localparam logic [11:0] FA = 12'h030;
  localparam logic [11:0] FB = 12'h034;
  localparam logic [11:0] EA = 12'h230;
  localparam logic [11:0] EB = 12'h234;
  localparam logic [11:0] OPT = 12'h204;
  localparam logic [11:0] REGS [9] = '{CORE, 12'h22C, 12'h42C, 12'h62C,
                                       FA, FB, EA, EB, OPT};
  localparam logic [11:0] EV_A [10] = '{CORE, FA, FA, FA, FA, FA, FA,
                                        FB, FB, FB};
  localparam logic [7:0] EV_M [10] = '{8'h04, 8'h80, 8'h40, 8'h08, 8'h04,
                                       8'h02, 8'h01, 8'h10, 8'h08, 8'h01};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_pin;
  logic [3:0]  pins;
  logic        rx_full;
  logic        tx_empty;
  logic        fire;
  logic [3:0]  sel;
  logic [10:0] pulse;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          miscompares;
  int          samples_checked;

  iefl_periph_model u_periph (.pclk(pclk), .presetn(presetn), .fire(fire),
    .sel(sel), .pulse(pulse));

  iefl_irq_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_zero_ovf(pulse[0]), .external_edge_pin(ext_pin),
    .port_b_pins(pins), .port_b_read(pulse[10]),
    .parallel_port_access(pulse[1]), .converter_done(pulse[2]),
    .serial_rx_full(rx_full), .serial_tx_empty(tx_empty),
    .sync_serial_event(pulse[3]), .capcmp_one_event(pulse[4]),
    .timer_two_match(pulse[5]), .timer_one_ovf(pulse[6]),
    .mem_write_done(pulse[7]), .bus_collision(pulse[8]),
    .capcmp_two_event(pulse[9]), .irq_request(irq));

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic xfer(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(logic [11:0] a, logic [7:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rchk(string n, logic [11:0] a, logic [7:0] e);
    xfer(1'h0, a, 8'h00);
    chk(n, {24'h000000, e}, rd);
  endtask

  task automatic pulse_ev(int s);
    @(posedge pclk);
    fire <= 1'h1;
    sel <= s[3:0];
    @(posedge pclk);
    fire <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic irq_is(logic e);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("irq_request", {31'h00000000, e}, {31'h00000000, irq});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    foreach (REGS[i]) rchk("reset value", REGS[i], 8'h00);
    wr(CORE, 8'h38);
    for (int i = 1; i < 4; i++) rchk("mirror", REGS[i], 8'h38);
    wr(REGS[3], 8'h00);
    rchk("mirror clear", CORE, 8'h00);
  endtask

  task automatic t_events();
    for (int i = 0; i < 10; i++) begin
      pulse_ev(i);
      rchk("flag", EV_A[i], EV_M[i]);
      wr(EV_A[i], 8'h00);
      rchk("flag clear", EV_A[i], 8'h00);
    end
    irq_is(1'h0);
  endtask

  task automatic t_gating();
    wr(EA, 8'h01);
    pulse_ev(6);
    irq_is(1'h0);
    wr(CORE, 8'h80);
    irq_is(1'h0);
    wr(CORE, 8'hC0);
    irq_is(1'h1);
    wr(FA, 8'h00);
    irq_is(1'h0);
    pulse_ev(6);
    irq_is(1'h1);
    wr(FA, 8'h00);
    wr(FA, 8'h01);
    irq_is(1'h1);
    wr(FA, 8'h00);
    wr(EA, 8'h00);
    wr(CORE, 8'hA0);
    pulse_ev(0);
    irq_is(1'h1);
    wr(CORE, 8'h80);
    irq_is(1'h0);
    wr(EB, 8'hBF);
    rchk("enables b", EB, 8'h19);
    wr(EB, 8'h00);
  endtask

  task automatic t_levels();
    wr(EA, 8'h20);
    wr(CORE, 8'hC0);
    rx_full <= 1'h1;
    irq_is(1'h1);
    wr(FA, 8'h00);
    rchk("rx flag", FA, 8'h20);
    rx_full <= 1'h0;
    tx_empty <= 1'h1;
    rchk("tx flag", FA, 8'h10);
    tx_empty <= 1'h0;
    wr(CORE, 8'h00);
    wr(EA, 8'h00);
    rchk("rx tx idle", FA, 8'h00);
  endtask

  // Six edges cover the two-stage synchroniser plus the edge detector.
  task automatic t_ext_pin();
    ext_pin <= 1'h0;
    repeat (6) @(posedge pclk);
    rchk("falling edge", CORE, 8'h02);
    wr(OPT, 8'h40);
    wr(CORE, 8'h90);
    ext_pin <= 1'h1;
    repeat (4) @(posedge pclk);
    irq_is(1'h1);
    rchk("rising edge", CORE, 8'h92);
    wr(CORE, 8'h00);
    ext_pin <= 1'h0;
    repeat (6) @(posedge pclk);
    rchk("edge ignored", CORE, 8'h00);
    wr(OPT, 8'h00);
  endtask

  task automatic t_port();
    pins <= 4'hA;
    repeat (6) @(posedge pclk);
    wr(CORE, 8'h00);
    rchk("mismatch holds", CORE, 8'h01);
    pulse_ev(10);
    wr(CORE, 8'h88);
    rchk("port cleared", CORE, 8'h88);
    irq_is(1'h0);
    @(posedge pclk);
    pins <= 4'h5;
    repeat (4) @(posedge pclk);
    irq_is(1'h1);
    pulse_ev(10);
    wr(CORE, 8'h00);
    rchk("port idle", CORE, 8'h00);
  endtask

  task automatic t_unmapped();
    xfer(1'h1, 12'h000, 8'hFF);
    chk("write pslverr", 32'h00000001, {31'h00000000, err});
    rchk("unmapped read", 12'h3FC, 8'h00);
    chk("read pslverr", 32'h00000001, {31'h00000000, err});
  endtask

  task automatic results();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ext_pin = 1'h1;
    pins = 4'h0;
    rx_full = 1'h0;
    tx_empty = 1'h0;
    fire = 1'h0;
    sel = 4'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_events();
    t_gating();
    t_levels();
    t_ext_pin();
    t_port();
    t_unmapped();
    results();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results();
  end
endmodule
